// ---- sac_conv_ctrl.sv ----
// sar converter conversion control with wishbone classic slave
// assumes timer overflow pulses on clk, convert pin asynchronous,
// analog comparator code presented on sample_code when conversion ends
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sac_conv_ctrl
	import sac_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire sac_timer_t timers,
	input wire logic external_convert_pin,
	input wire logic [9:0] sample_code,
	output logic converter_power,
	output logic tracking,
	output logic conversion_busy,
	output logic converter_irq
);
	sac_reg_t r;
	sac_reg_t next_r;
	logic sar_tick;
	logic start_evt;
	logic pin_rise;
	logic t2_evt;
	logic eight;
	logic wr;
	logic [9:0] code;

	assign eight = r.cfg[SAC_CFG_8B];
	assign sar_tick = (r.div_cnt == r.cfg[7:SAC_CFG_SC_LSB]); // R8 R9
	assign pin_rise = r.pin_s2 && !r.pin_d; // R19
	assign t2_evt = timers.t2_split ? timers.t2_low_ovf :
		timers.t2_high_ovf; // R15
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !r.ack;

	always_comb begin
		// R10 R11
		if (r.ctl[2]) begin
			start_evt = pin_rise;
		end else if (r.ctl[1:0] == SAC_CM_T0[1:0]) begin
			start_evt = timers.t0_ovf;
		end else if (r.ctl[1:0] == SAC_CM_T2[1:0]) begin
			start_evt = t2_evt;
		end else if (r.ctl[1:0] == SAC_CM_T1[1:0]) begin
			start_evt = timers.t1_ovf;
		end else begin
			start_evt = wr && wb_sel_i[0] && wb_adr_i == SAC_ADDR_CTRL &&
				wb_dat_i[SAC_CTL_BUSY];
		end
	end

	always_comb begin
		next_r = r;
		code = sample_code;
		if (eight) begin
			code = {sample_code[9:2], 2'b00}; // R5
		end
		next_r.pin_s1 = external_convert_pin;
		next_r.pin_s2 = r.pin_s1;
		next_r.pin_d = r.pin_s2;
		next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
		next_r.dat = 32'h0000_0000;
		if (wb_cyc_i && wb_stb_i && !r.ack) begin
			if (wb_adr_i == SAC_ADDR_CTRL) begin
				next_r.dat = {24'h00_0000, r.ctl};
			end else if (wb_adr_i == SAC_ADDR_CFG) begin
				next_r.dat = {24'h00_0000, r.cfg};
			end else if (wb_adr_i == SAC_ADDR_HIGH) begin
				next_r.dat = {24'h00_0000, r.high};
			end else if (wb_adr_i == SAC_ADDR_LOW) begin
				next_r.dat = {24'h00_0000, r.low};
			end else begin
				next_r.dat = 32'h0000_0000;
			end
		end
		if (wr && wb_sel_i[0]) begin
			if (wb_adr_i == SAC_ADDR_CTRL) begin
				// busy is hardware owned; writing it only starts
				next_r.ctl = {wb_dat_i[7:5], r.ctl[SAC_CTL_BUSY],
					wb_dat_i[3:0]};
			end else if (wb_adr_i == SAC_ADDR_CFG) begin
				next_r.cfg = wb_dat_i[7:0];
			end
		end
		// sar clock divider, free running while enabled
		if (!r.ctl[SAC_CTL_EN] || sar_tick) begin
			next_r.div_cnt = 5'h00;
		end else begin
			next_r.div_cnt = r.div_cnt + 5'h01;
		end
		case (r.st)
			SAC_IDLE: begin
				if (r.ctl[SAC_CTL_EN] && start_evt) begin
					next_r.ctl[SAC_CTL_BUSY] = 1'b1; // R12
					next_r.sar_cnt = 5'h00;
					next_r.div_cnt = 5'h00;
					// R7 R20 R21
					next_r.end_cnt = SAC_END_10 -
						(eight ? SAC_SHORT_8 : 5'h00) +
						(r.ctl[SAC_CTL_TM] ? SAC_TRACK_EXTRA : 5'h00);
					next_r.st = r.ctl[SAC_CTL_TM] ? SAC_TRACK : SAC_CONV;
					// R16 R17
				end
			end
			SAC_TRACK: begin
				if (sar_tick) begin
					next_r.sar_cnt = r.sar_cnt + 5'h01;
					if (r.sar_cnt + 5'h01 == SAC_TRACK_EXTRA) begin
						next_r.st = SAC_CONV; // R16
					end
				end
			end
			default: begin
				if (sar_tick) begin
					next_r.sar_cnt = r.sar_cnt + 5'h01;
					if (r.sar_cnt + 5'h01 == r.end_cnt) begin
						next_r.st = SAC_IDLE;
						next_r.ctl[SAC_CTL_BUSY] = 1'b0; // R12
						next_r.ctl[SAC_CTL_DONE] = 1'b1; // R13
						// R2 R3 R4 R6 R22
						if (eight || !r.cfg[SAC_CFG_LJ]) begin
							next_r.high = eight ? code[9:2] :
								{6'h00, code[9:8]};
							next_r.low = eight ? 8'h00 : code[7:0];
						end else begin
							next_r.high = code[9:2];
							next_r.low = {code[1:0], 6'h00};
						end
						next_r.code = code;
					end
				end
			end
		endcase
		if (!r.ctl[SAC_CTL_EN]) begin
			// R1
			next_r.st = SAC_IDLE;
			next_r.ctl[SAC_CTL_BUSY] = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '{st: SAC_IDLE, ctl: SAC_CTL_RESET, cfg: SAC_CFG_RESET,
				default: '0};
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign converter_power = r.ctl[SAC_CTL_EN]; // R1
	assign conversion_busy = r.ctl[SAC_CTL_BUSY];
	// R18 R19
	assign tracking = r.ctl[SAC_CTL_EN] && (r.st != SAC_CONV) &&
		(!r.ctl[2] || r.ctl[SAC_CTL_TM] || !r.pin_s2 ||
		r.st == SAC_TRACK);
	assign converter_irq = r.ctl[SAC_CTL_DONE] && r.ctl[SAC_CTL_IE]; // R13
endmodule // sac_conv_ctrl
`default_nettype wire

// ---- sac_conv_ctrl_sva.sv ----
// checker of the conversion control block's port timing
// assumes one clock domain; bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module sac_conv_ctrl_sva (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic converter_power,
	input wire logic tracking,
	input wire logic conversion_busy,
	input wire logic converter_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_take;
		ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// shortest run is twelve sar clocks, longest 17 at divider 31
	sequence s_run;
		conversion_busy [*8] ##[1:600] !conversion_busy;
	endsequence
	a_busy_powered: assert property (
		conversion_busy |-> converter_power)
		else $error("busy while shut down");
	a_shutdown_quiet: assert property (
		!converter_power |-> !tracking)
		else $error("tracking while shut down");
	a_take_ack: assert property (
		s_take |=> wb_ack_o)
		else $error("request not answered");
	// a frozen clock enable holds ack, so only a live cycle must drop it
	a_ack_pulse: assert property (
		ce && wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_upper: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_conv_len: assert property (
		$rose(conversion_busy) |-> s_run)
		else $error("conversion length wrong");
	a_irq_cause: assert property (
		$rose(converter_irq) |-> $fell(conversion_busy) || wb_ack_o)
		else $error("irq without cause");
endmodule // sac_conv_ctrl_sva
bind sac_conv_ctrl sac_conv_ctrl_sva chk (.clk, .rstn, .ce, .wb_cyc_i,
	.wb_stb_i, .wb_dat_o, .wb_ack_o, .converter_power, .tracking,
	.conversion_busy, .converter_irq);
`default_nettype wire

// ---- sac_far_model.sv ----
// timers beside the converter: one-cycle overflow pulses on command
// assumes fire codes 1..3 follow the start source codes, 4 the wrong byte
`timescale 1ns/1ps
`default_nettype none
module sac_far_model
	import sac_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] fire,
	input wire logic split,
	output sac_timer_t timers
);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timers <= '0;
		end else begin
			timers.t0_ovf <= fire == SAC_CM_T0;
			timers.t1_ovf <= fire == SAC_CM_T1;
			// fire 4 pulses only the byte the converter must ignore
			timers.t2_low_ovf <= split ? fire == SAC_CM_T2 : fire == 3'h4;
			timers.t2_high_ovf <= split ? fire == 3'h4 : fire == SAC_CM_T2;
			timers.t2_split <= split;
		end
	end
endmodule // sac_far_model
`default_nettype wire

// ---- sac_pkg.sv ----
// package for the sar converter conversion control block
// assumes a wishbone classic slave, 32-bit data, one clock
// Behaviour
// R1: converter runs only while converter_enable is 1, else shut down
// R2: each completed conversion loads result bytes as unsigned 10-bit code
// R3: left_justify_select 0 puts code in low ten bits, 1 in top ten
// R4: unused result bits always read zero
// R5: eight-bit mode resolves top 8 bits into result_high_byte
// R6: eight-bit mode ignores left_justify_select
// R7: eight-bit conversion takes two fewer sar clocks than ten-bit
// R8: sar clock is system clock divided by programmable divider
// R9: divider field is 5 bits, sar period is clk period times field plus one
// R10: start from software busy write, timer 0/2/1 overflow, or pin rise
// R11: source select 000 sw, 001 t0, 010 t2, 011 t1, 1xx pin
// R12: busy reads 1 during conversion, clears itself on completion
// R13: busy falling edge sets done flag and raises interrupt when enabled
// R14: software polls done flag and reads results only after it is set
// R15: timer 2 source uses low-byte overflow in 8-bit, high-byte in 16-bit
// R16: delayed tracking adds three sar clocks of tracking before converting
// R17: without delayed tracking conversion starts at once
// R18: internal sources track whenever not converting
// R19: pin source tracks if delayed, or pin low; converts on rising edge
// R20: eight-bit ends at sar clock 15 delayed, 12 not delayed
// R21: ten-bit ends at sar clock 17 delayed, 14 not delayed
// R22: eight-bit mode low result byte reads all zeros
package sac_pkg;
	localparam logic [7:0] SAC_ADDR_CTRL = 8'h00;
	localparam logic [7:0] SAC_ADDR_CFG = 8'h04;
	localparam logic [7:0] SAC_ADDR_HIGH = 8'h08;
	localparam logic [7:0] SAC_ADDR_LOW = 8'h0C;
	localparam logic [7:0] SAC_ADDR_SAMPLE = 8'h10;
	// control register fields
	localparam int SAC_CTL_EN = 7;
	localparam int SAC_CTL_TM = 6;
	localparam int SAC_CTL_DONE = 5;
	localparam int SAC_CTL_BUSY = 4;
	localparam int SAC_CTL_IE = 3;
	localparam int SAC_CTL_CM_LSB = 0;
	// config register fields
	localparam int SAC_CFG_SC_LSB = 3;
	localparam int SAC_CFG_LJ = 2;
	localparam int SAC_CFG_8B = 1;
	localparam int SAC_CFG_GAIN = 0;
	localparam logic [7:0] SAC_CFG_RESET = 8'hF9;
	localparam logic [7:0] SAC_CTL_RESET = 8'h00;
	localparam logic [2:0] SAC_CM_SW = 3'h0;
	localparam logic [2:0] SAC_CM_T0 = 3'h1;
	localparam logic [2:0] SAC_CM_T2 = 3'h2;
	localparam logic [2:0] SAC_CM_T1 = 3'h3;
	// conversion lengths in sar clocks
	localparam logic [4:0] SAC_TRACK_EXTRA = 5'h03;
	localparam logic [4:0] SAC_END_10 = 5'h0E;
	localparam logic [4:0] SAC_SHORT_8 = 5'h02;

	typedef enum logic [1:0] {SAC_IDLE, SAC_TRACK, SAC_CONV} sac_state_t;

	typedef struct packed {
		logic t0_ovf;
		logic t1_ovf;
		logic t2_low_ovf;
		logic t2_high_ovf;
		logic t2_split;
	} sac_timer_t;

	typedef struct packed {
		sac_state_t st;
		logic [7:0] ctl;
		logic [7:0] cfg;
		logic [7:0] high;
		logic [7:0] low;
		logic [4:0] div_cnt;
		logic [4:0] sar_cnt;
		logic [4:0] end_cnt;
		logic [9:0] code;
		logic pin_s1;
		logic pin_s2;
		logic pin_d;
		logic ack;
		logic [31:0] dat;
	} sac_reg_t;
endpackage

// ---- tb_sar_adc_conversion_control.sv ----
// random conversions over every start source and result format
// assumes the block answers wishbone reads and writes of ctl and cfg
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
	fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_sar_adc_conversion_control import sac_pkg::*;;
	logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, pin = 0, split = 0;
	logic [7:0] adr = '0;
	logic [31:0] dw = '0, q, rd, dat_o;
	logic [9:0] code = '0;
	logic [2:0] fire = '0, src;
	logic [4:0] dv;
	logic lj, b8, dt, ie, ack, pwr, trk, busy, irq;
	sac_timer_t tm;
	int fail_count = 0, cmp_count = 0, n, e, seed;
	always #50 clk = ~clk;
	sac_far_model far (.clk(clk), .rstn(rstn), .fire(fire),
		.split(split), .timers(tm));
	sac_conv_ctrl uut (.clk(clk), .rstn(rstn), .ce(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dw),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .timers(tm),
		.external_convert_pin(pin), .sample_code(code),
		.converter_power(pwr), .tracking(trk),
		.conversion_busy(busy), .converter_irq(irq));
	// no cycle limit here: a missing ack is left to the watchdog
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_o;
		{cyc, stb} <= 2'b00;
	endtask
	function automatic logic [31:0] ctl(logic b);
		return {24'h00_0000, 1'b1, dt, 1'b0, b, ie, src};
	endfunction
	function automatic logic [15:0] exp_res(logic [9:0] c, logic l, logic b);
		if (b) return {c[9:2], 8'h00};
		return l ? {c, 6'h00} : {6'h00, c};
	endfunction
	task automatic final_report();
		if (fail_count == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#3_000_000;
		fail_count++;
		final_report();
	end
	initial begin
		seed = $urandom(32'h1aad);
		repeat (3) @(posedge clk);
		rstn <= 1;
		wb(0, SAC_ADDR_CFG, 0);
		`CHK(q[7:0], SAC_CFG_RESET)
		wb(0, SAC_ADDR_CTRL, 0);
		`CHK(q[7:0], SAC_CTL_RESET)
		`CHK(pwr, 1'b0)
		wb(0, 8'h20, 0);
		`CHK(q, 32'h0000_0000)
		wb(1, SAC_ADDR_CTRL, 32'h0000_0010);
		repeat (4) @(posedge clk);
		`CHK(busy, 1'b0)
		`CHK(trk, 1'b0)
		for (int i = 0; i < 24; i++) begin
			// first eight passes cover every source code, 1xx included
			src = (i < 8) ? 3'(i) : 3'($urandom_range(0, 4));
			{dv, lj, b8, dt, ie} = {5'($urandom_range(0, 3)), 4'($urandom)};
			split <= 1'($urandom);
			code <= (i == 8) ? 10'h3FF : 10'($urandom);
			wb(1, SAC_ADDR_CFG, {24'h00_0000, dv, lj, b8, 1'b1});
			wb(1, SAC_ADDR_CTRL, ctl(1'b0));
			`CHK(trk, 1'b1)
			`CHK(pwr, 1'b1)
			if (src == SAC_CM_T2) begin
				fire <= 3'h4;
				@(posedge clk);
				fire <= '0;
				repeat (4) @(posedge clk);
				`CHK(busy, 1'b0)
			end
			if (src == SAC_CM_SW) begin
				wb(1, SAC_ADDR_CTRL, ctl(1'b1));
			end else if (src < 3'h4) begin
				fire <= src;
				@(posedge clk);
				fire <= '0;
			end else begin
				pin <= 1'b1;
			end
			n = 0;
			while (busy !== 1'b1 && n < 20) begin
				@(posedge clk);
				n++;
			end
			// first cycle of the run: tracking only while delayed
			`CHK(trk, dt)
			n = 0;
			while (busy === 1'b1 && n < 900) begin
				@(posedge clk);
				n++;
			end
			e = (b8 ? 12 : 14) + (dt ? 3 : 0);
			`CHK(n, e * (dv + 1))
			pin <= 1'b0;
			wb(0, SAC_ADDR_CTRL, 0);
			`CHK(q[5:4], 2'b10)
			`CHK(irq, ie)
			wb(0, SAC_ADDR_HIGH, 0);
			rd = q;
			wb(0, SAC_ADDR_LOW, 0);
			rd = {rd[23:0], q[7:0]};
			`CHK(rd[15:0], exp_res(code, lj, b8))
			wb(1, SAC_ADDR_CTRL, ctl(1'b0));
			`CHK(irq, 1'b0)
		end
		final_report();
	end
endmodule // tb_sar_adc_conversion_control
`default_nettype wire
